// ==== src/pcs_packet_status.sv ====
// packet command status sequencer: bus release, service request and completion outputs
//
// Function
// (R1) after the whole packet arrives, raise busy and drop data request first
// (R2) data needed, overlap, release interrupt off, data not ready: release allowed
// (R3) data needed, overlap, release interrupt on: always release the bus
// (R4) release: reason shows REL one, I/O and C/D zero; byte counts meaningless
// (R5) release: clear busy, dma ready, data request and check; ready bit meaningless
// (R6) queuing with overlap: report the command tag, any value 0 to 31
// (R7) every output phase sets service when another queued command waits
// (R8) after release, when ready, set service and leave all other bits alone
// (R9) on a service command present data, completion or error outputs as needed
// (R10) clean completion: REL zero, I/O and C/D one, idle status, ready set
// (R11) no error ending before the host has written the last packet byte
// (R12) error: sense key in upper error bits, abort for invalid code or parameter
// (R13) end-of-medium and illegal-length bits pass through from the command set
// (R14) error end: completion reason bits, ready set, check set when error nonzero
// (R15) error end: fault bit set when a device fault occurred
// (R16) the packet command is taken whatever the ready bit shows
// (R17) short commands start at packet byte 0; packet size code in two bits
// (R18) overlap with release interrupt off: start at once if ready, else release; the code releases only when CTRL_OPTREL is set, else stays busy
// (R19) host sets the overlap bit in features to ask for an overlapped command
// (R20) host waits for service before sending the service command after a release
module pcs_packet_status
	import pcs_pkg::*;
#(
	parameter logic [7:0] SERVICE_CODE  = CMD_SERVICE,
	parameter logic [1:0] PKT_SIZE_CODE = 2'h0
) (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RST,
	// register port
	input  wire logic [2:0]          ADDR,
	input  wire logic [7:0]          WDATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output logic      [7:0]          RDATA,
	// device capabilities
	input  wire logic                OVERLAP_SUPPORTED,
	input  wire logic                QUEUE_SUPPORTED,
	input  wire logic                OTHER_QUEUED,
	// command engine events
	input  wire logic                PKT_RECEIVED,
	input  wire logic                NEED_XFER,
	input  wire logic                DATA_READY,
	input  wire logic                XFER_TO_HOST,
	input  wire logic                XFER_DONE,
	input  wire logic                FINISH,
	input  wire logic [SENSE_W-1:0]  FIN_SENSE,
	input  wire logic                FIN_ABRT,
	input  wire logic                FIN_EOM,
	input  wire logic                FIN_ILI,
	input  wire logic                FIN_FAULT,
	// phase strobes and held command-active level to the command engine
	output logic                     PKT_ACCEPT,
	output logic                     XFER_GO,
	output logic                     CMD_ACTIVE
);
	import pcs_pkg::*;

	if (SERVICE_CODE == CMD_PACKET) begin : g_bad_code
		$error("service code must differ from the packet command code");
	end

	////////////////////////////////////////////////////////////////////////////
	pcs_bus_if bus ();

	pcs_reg_port u_port (
		.clk   (CLK),
		.rst   (RST),
		.addr  (ADDR),
		.wdata (WDATA),
		.wr    (WR),
		.rd    (RD),
		.rdata (RDATA),
		.bus   (bus)
	);

	pcs_state_t         state_reg;
	logic [7:0]         feat_reg;
	logic [7:0]         cnt_reg;
	logic [7:0]         dev_reg;
	logic [7:0]         ctrl_reg;
	logic               ovl_reg;
	logic               dma_reg;
	logic               need_reg;
	logic [TAG_W-1:0]   tag_reg;
	logic               rel_reg;
	logic               io_reg;
	logic               cd_reg;
	logic               bsy_reg;
	logic               drdy_reg;
	logic               b5_reg;
	logic               serv_reg;
	logic               drq_reg;
	logic               chk_reg;
	logic [7:0]         err_reg;
	logic [SENSE_W-1:0] fin_sense_reg;
	logic               fin_abrt_reg;
	logic               fin_eom_reg;
	logic               fin_ili_reg;
	logic               fin_fault_reg;
	logic               fin_pend;

	////////////////////////////////////////////////////////////////////////////
	// phase decisions
	logic               wr_packet;
	logic               wr_service;
	logic               in_busy;
	logic               overlapped;
	logic               other_q;
	logic               must_release;
	logic               may_release;
	logic               go_busy;
	logic               go_release;
	logic               go_serv;
	logic               go_data;
	logic               go_done;
	logic               fin_live;
	logic [TAG_W-1:0]   tag_field;
	logic [SENSE_W-1:0] sense_w;
	logic               abrt_w;
	logic               eom_w;
	logic               ili_w;
	logic               fault_w;
	logic [7:0]         err_next;

	// accepted in idle with no look at the ready bit
	assign wr_packet  = bus.wr_cmd && bus.wdata == CMD_PACKET && state_reg == ST_IDLE; // R16
	assign wr_service = bus.wr_cmd && bus.wdata == SERVICE_CODE && state_reg == ST_SERV_WAIT;
	assign in_busy    = state_reg == ST_PKT_BUSY;
	assign overlapped = ovl_reg && OVERLAP_SUPPORTED; // R19
	assign other_q    = OTHER_QUEUED && OVERLAP_SUPPORTED;
	// busy only once the last packet byte is in, so no ending can come earlier
	assign go_busy = (state_reg == ST_PKT_WAIT && PKT_RECEIVED)
		|| (state_reg == ST_DATA && XFER_DONE); // R1 R11
	assign must_release = in_busy && need_reg && overlapped && ctrl_reg[CTRL_RELINT]; // R3
	// optional release is taken only when software allows it; after the data
	// phase the same option lets the device release while it finishes
	assign may_release = in_busy && overlapped && !ctrl_reg[CTRL_RELINT]
		&& ctrl_reg[CTRL_OPTREL] && (need_reg ? !DATA_READY : !FINISH); // R2 R18
	assign go_release = must_release || may_release;
	assign go_serv = state_reg == ST_RELEASED
		&& ((need_reg && DATA_READY) || (!need_reg && FINISH)); // R8
	assign go_data = (in_busy && need_reg && !go_release && DATA_READY)
		|| (wr_service && !fin_pend); // R9 R18
	assign go_done = (in_busy && !need_reg && !go_release && FINISH)
		|| (wr_service && fin_pend); // R9
	assign tag_field = (QUEUE_SUPPORTED && OVERLAP_SUPPORTED && feat_reg[FEAT_OVL])
		? cnt_reg[IR_TAG_LSB +: TAG_W] : '0; // R6

	// a finish seen in this cycle is used directly, a held one after a service
	assign fin_live = FINISH && in_busy;
	assign sense_w  = fin_live ? FIN_SENSE : fin_sense_reg;
	assign abrt_w   = fin_live ? FIN_ABRT : fin_abrt_reg;
	assign eom_w    = fin_live ? FIN_EOM : fin_eom_reg;
	assign ili_w    = fin_live ? FIN_ILI : fin_ili_reg;
	assign fault_w  = fin_live ? FIN_FAULT : fin_fault_reg;
	assign err_next = {sense_w, 1'b0, abrt_w, eom_w, ili_w}; // R12 R13

	pcs_event_hold u_fin_hold (
		.clk (CLK),
		.rst (RST),
		.set (go_serv && !need_reg),
		.clr (go_done),
		.q   (fin_pend)
	);

	////////////////////////////////////////////////////////////////////////////
	// phase state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: if (wr_packet) state_reg <= ST_PKT_WAIT;
				ST_PKT_WAIT: if (go_busy) state_reg <= ST_PKT_BUSY;
				ST_PKT_BUSY: begin
					if (go_release) state_reg <= ST_RELEASED;
					else if (go_data) state_reg <= ST_DATA;
					else if (go_done) state_reg <= ST_IDLE;
				end
				ST_RELEASED: if (go_serv) state_reg <= ST_SERV_WAIT;
				ST_SERV_WAIT: begin
					if (go_data) state_reg <= ST_DATA;
					else if (go_done) state_reg <= ST_IDLE;
				end
				ST_DATA: if (go_busy) state_reg <= ST_PKT_BUSY;
			endcase
		end
	end

	// host-written registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			feat_reg <= REG_RST;
			cnt_reg  <= REG_RST;
			dev_reg  <= REG_RST;
			ctrl_reg <= REG_RST;
		end else begin
			if (bus.wr_feat) feat_reg <= bus.wdata;
			if (bus.wr_cnt) cnt_reg <= bus.wdata;
			if (bus.wr_dev) dev_reg <= bus.wdata;
			if (bus.wr_ctrl) ctrl_reg <= bus.wdata & CTRL_MASK;
		end
	end

	// command context taken at acceptance and at packet arrival
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ovl_reg  <= 1'b0;
			dma_reg  <= 1'b0;
			need_reg <= 1'b0;
		end else begin
			if (wr_packet) begin
				ovl_reg <= feat_reg[FEAT_OVL];
				dma_reg <= feat_reg[FEAT_DMA];
			end
			if (state_reg == ST_PKT_WAIT && PKT_RECEIVED) need_reg <= NEED_XFER;
			else if (state_reg == ST_DATA && XFER_DONE) need_reg <= 1'b0;
		end
	end

	// completion details held across a release
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fin_sense_reg <= '0;
			fin_abrt_reg  <= 1'b0;
			fin_eom_reg   <= 1'b0;
			fin_ili_reg   <= 1'b0;
			fin_fault_reg <= 1'b0;
		end else if (FINISH && (in_busy || state_reg == ST_RELEASED)) begin
			fin_sense_reg <= FIN_SENSE;
			fin_abrt_reg  <= FIN_ABRT;
			fin_eom_reg   <= FIN_EOM;
			fin_ili_reg   <= FIN_ILI;
			fin_fault_reg <= FIN_FAULT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt reason
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tag_reg <= '0;
			rel_reg <= 1'b0;
			io_reg  <= 1'b0;
			cd_reg  <= 1'b0;
		end else if (wr_packet) begin
			tag_reg <= tag_field; // R6
			rel_reg <= 1'b0;
			io_reg  <= 1'b0;
			cd_reg  <= 1'b1;
		end else if (go_release) begin
			rel_reg <= 1'b1; // R4
			io_reg  <= 1'b0; // R4
			cd_reg  <= 1'b0; // R4
		end else if (go_data) begin
			rel_reg <= 1'b0;
			io_reg  <= XFER_TO_HOST;
			cd_reg  <= 1'b0;
		end else if (go_done) begin
			rel_reg <= 1'b0; // R10 R14
			io_reg  <= 1'b1; // R10 R14
			cd_reg  <= 1'b1; // R10 R14
		end
	end

	// status; a service request touches only the service bit
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bsy_reg  <= 1'b0;
			drdy_reg <= DRDY_RST;
			b5_reg   <= 1'b0;
			serv_reg <= 1'b0;
			drq_reg  <= 1'b0;
			chk_reg  <= 1'b0;
		end else if (wr_packet) begin
			bsy_reg  <= 1'b0;
			b5_reg   <= 1'b0;
			serv_reg <= other_q; // R7
			drq_reg  <= 1'b1;
			chk_reg  <= 1'b0;
		end else if (go_busy) begin
			bsy_reg <= 1'b1; // R1
			drq_reg <= 1'b0; // R1
		end else if (go_release) begin
			bsy_reg  <= 1'b0; // R5
			b5_reg   <= 1'b0; // R5
			serv_reg <= other_q; // R7
			drq_reg  <= 1'b0; // R5
			chk_reg  <= 1'b0; // R5
		end else if (go_serv) begin
			serv_reg <= 1'b1; // R8
		end else if (go_data) begin
			bsy_reg  <= 1'b0;
			b5_reg   <= dma_reg && OVERLAP_SUPPORTED;
			serv_reg <= other_q; // R7
			drq_reg  <= 1'b1;
			chk_reg  <= 1'b0;
		end else if (go_done) begin
			bsy_reg  <= 1'b0; // R10 R14
			drdy_reg <= 1'b1; // R10 R14
			b5_reg   <= fault_w; // R15
			serv_reg <= other_q; // R7
			drq_reg  <= 1'b0; // R10 R14
			chk_reg  <= |err_next; // R14
		end
	end

	// error report changes only when a command ends
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			err_reg <= ERR_RST;
		end else if (go_done) begin
			err_reg <= err_next; // R12 R13
		end
	end

	// strobes and held command-active level to the command engine
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PKT_ACCEPT <= 1'b0;
			XFER_GO    <= 1'b0;
			CMD_ACTIVE <= 1'b0;
		end else begin
			PKT_ACCEPT <= wr_packet;
			XFER_GO    <= go_data;
			if (wr_packet) CMD_ACTIVE <= 1'b1;
			else if (go_done) CMD_ACTIVE <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read-back
	assign bus.err   = err_reg;
	assign bus.irsn  = {tag_reg, rel_reg, io_reg, cd_reg};
	assign bus.dev   = dev_reg;
	assign bus.ctrl  = ctrl_reg;
	assign bus.ident = {6'h00, PKT_SIZE_CODE}; // R17
	assign bus.stat  = {bsy_reg, drdy_reg, b5_reg, serv_reg, drq_reg, 2'b00, chk_reg};

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	busy_after_pkt_a: assert property (state_reg == ST_PKT_WAIT && PKT_RECEIVED // R1
		|=> bsy_reg && !drq_reg && state_reg == ST_PKT_BUSY)
		else $error("busy not raised after packet");
	forced_release_a: assert property (in_busy && need_reg && overlapped // R3
		&& ctrl_reg[CTRL_RELINT] |=> state_reg == ST_RELEASED && rel_reg)
		else $error("release not performed with release interrupt on");
	release_reason_a: assert property ($rose(state_reg == ST_RELEASED) // R4
		|-> rel_reg && !io_reg && !cd_reg)
		else $error("release reason bits wrong");
	release_status_a: assert property (state_reg == ST_RELEASED // R5
		|-> !bsy_reg && !drq_reg && !chk_reg && !b5_reg)
		else $error("release status bits wrong");
	tag_report_a: assert property (wr_packet && QUEUE_SUPPORTED && OVERLAP_SUPPORTED // R6
		&& feat_reg[FEAT_OVL] |=> tag_reg == $past(cnt_reg[7:3]))
		else $error("tag not reported");
	serv_only_a: assert property (go_serv |=> serv_reg && $stable(bsy_reg) // R8
		&& $stable(drq_reg) && $stable(chk_reg) && $stable(rel_reg) && $stable(err_reg))
		else $error("service request changed other bits");
	service_answer_a: assert property (wr_service // R9
		|=> (state_reg == ST_DATA && drq_reg) || (state_reg == ST_IDLE && cd_reg && io_reg))
		else $error("service command not answered");
	clean_done_a: assert property (go_done && err_next == 8'h00 // R10
		|=> !rel_reg && io_reg && cd_reg && !bsy_reg && !drq_reg && !chk_reg && drdy_reg)
		else $error("completion outputs wrong");
	no_early_end_a: assert property (state_reg == ST_PKT_WAIT |-> !go_done // R11
		##1 (state_reg != ST_IDLE))
		else $error("command ended before packet complete");
	error_end_a: assert property (go_done // R12 R14 R15
		|=> chk_reg == (|err_reg) && b5_reg == $past(fault_w) && !bsy_reg && drdy_reg)
		else $error("error outputs wrong");
	queued_serv_a: assert property ((wr_packet || go_data || go_done) // R7
		|=> serv_reg == $past(other_q))
		else $error("service bit not following queue");
	take_packet_a: assert property (bus.wr_cmd && bus.wdata == CMD_PACKET // R16
		&& state_reg == ST_IDLE |=> state_reg == ST_PKT_WAIT && PKT_ACCEPT)
		else $error("packet command refused");

	release_path_c: cover property (state_reg == ST_RELEASED ##[1:50] wr_service);
	direct_data_c: cover property (in_busy && go_data);
	error_end_c: cover property (go_done && |err_next);
	serv_done_c: cover property (wr_service && fin_pend);
endmodule

// ==== src/pcs_pkg.sv ====
// shared constants, register map and phase states of the packet status sequencer
package pcs_pkg;
	// register port offsets (read meaning / write meaning)
	localparam logic [2:0] ADR_ERR_FEAT = 3'h0;
	localparam logic [2:0] ADR_IRSN_CNT = 3'h1;
	localparam logic [2:0] ADR_DEVSEL   = 3'h2;
	localparam logic [2:0] ADR_STAT_CMD = 3'h3;
	localparam logic [2:0] ADR_CTRL     = 3'h4;
	localparam logic [2:0] ADR_IDENT    = 3'h5;
	// interrupt reason fields
	localparam int IR_CD      = 0;
	localparam int IR_IO      = 1;
	localparam int IR_REL     = 2;
	localparam int IR_TAG_LSB = 3;
	localparam int TAG_W      = 5;
	// status fields; bit 5 is dma ready in transfer phases and fault at the end
	localparam int ST_CHK     = 0;
	localparam int ST_DRQ     = 3;
	localparam int ST_SERV    = 4;
	localparam int ST_DMRD_DF = 5;
	localparam int ST_DRDY    = 6;
	localparam int ST_BSY     = 7;
	// error report fields
	localparam int ER_ILI       = 0;
	localparam int ER_EOM       = 1;
	localparam int ER_ABRT      = 2;
	localparam int ER_SENSE_LSB = 4;
	localparam int SENSE_W      = 4;
	// features and control bits
	localparam int FEAT_DMA    = 0;
	localparam int FEAT_OVL    = 1;
	localparam int CTRL_RELINT = 0;
	localparam int CTRL_OPTREL = 1;
	localparam logic [7:0] CTRL_MASK = 8'h03;
	// command codes
	localparam logic [7:0] CMD_PACKET  = 8'hA0;
	localparam logic [7:0] CMD_SERVICE = 8'hA2;
	// reset values
	localparam logic [7:0] ERR_RST  = 8'h00;
	localparam logic [7:0] REG_RST  = 8'h00;
	localparam logic       DRDY_RST = 1'b1;

	typedef enum {
		ST_IDLE,
		ST_PKT_WAIT,
		ST_PKT_BUSY,
		ST_RELEASED,
		ST_SERV_WAIT,
		ST_DATA
	} pcs_state_t;
endpackage

// ==== src/pcs_bus_if.sv ====
// write decode and read-back values between the register port and the sequencer
interface pcs_bus_if;
	logic       wr_feat;
	logic       wr_cnt;
	logic       wr_dev;
	logic       wr_cmd;
	logic       wr_ctrl;
	logic [7:0] wdata;
	logic [7:0] err;
	logic [7:0] irsn;
	logic [7:0] stat;
	logic [7:0] dev;
	logic [7:0] ctrl;
	logic [7:0] ident;
	modport slave (output wr_feat, wr_cnt, wr_dev, wr_cmd, wr_ctrl, wdata,
		input err, irsn, stat, dev, ctrl, ident);
	modport core (input wr_feat, wr_cnt, wr_dev, wr_cmd, wr_ctrl, wdata,
		output err, irsn, stat, dev, ctrl, ident);
endinterface

// ==== src/pcs_reg_port.sv ====
// register port slave: write strobes decoded, read data registered one cycle later
module pcs_reg_port
	import pcs_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// plain register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// towards the sequencer
	pcs_bus_if.slave        bus
);
	function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
		return a == want;
	endfunction

	assign bus.wdata   = wdata;
	assign bus.wr_feat = wr && hit(addr, ADR_ERR_FEAT);
	assign bus.wr_cnt  = wr && hit(addr, ADR_IRSN_CNT);
	assign bus.wr_dev  = wr && hit(addr, ADR_DEVSEL);
	assign bus.wr_cmd  = wr && hit(addr, ADR_STAT_CMD);
	assign bus.wr_ctrl = wr && hit(addr, ADR_CTRL);

	// unmapped reads answer zero; data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				ADR_ERR_FEAT: rdata <= bus.err;
				ADR_IRSN_CNT: rdata <= bus.irsn;
				ADR_DEVSEL:   rdata <= bus.dev;
				ADR_STAT_CMD: rdata <= bus.stat;
				ADR_CTRL:     rdata <= bus.ctrl;
				ADR_IDENT:    rdata <= bus.ident;
				default:      rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// ==== src/pcs_event_hold.sv ====
// sticky event flag; a set in the same cycle as a clear wins
module pcs_event_hold (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// event in, clear in, flag out
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule

// ==== verif/pcs_host_model.sv ====
// host adapter model: task file master cycles on the plain register port
module pcs_host_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [2:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// data inverted after the strobe so a stale value is never mistaken for a held one
	task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
endmodule

// ==== verif/pcs_packet_status_tb_top.sv ====
// self-checking bench for the packet status sequencer
module pcs_packet_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;

	logic       clk, rst, wr, rd, oq, pkt, need, rdy, done, fin;
	logic       abrt, eom, ili, flt, act, acc, xgo;
	logic [7:0] n_acc, n_go;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v, s;
	logic [3:0] sense;
	int         num_errors, checked, cyc;

	pcs_host_model pcs_host_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));

	pcs_packet_status #(.PKT_SIZE_CODE(2'h1)) pcs_packet_status_i (
		.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .OVERLAP_SUPPORTED(1'b1), .QUEUE_SUPPORTED(1'b1),
		.OTHER_QUEUED(oq), .PKT_RECEIVED(pkt), .NEED_XFER(need), .DATA_READY(rdy),
		.XFER_TO_HOST(1'b1), .XFER_DONE(done), .FINISH(fin), .FIN_SENSE(sense),
		.FIN_ABRT(abrt), .FIN_EOM(eom), .FIN_ILI(ili), .FIN_FAULT(flt),
		.PKT_ACCEPT(acc), .XFER_GO(xgo), .CMD_ACTIVE(act));

	// engine strobes are one-cycle pulses, so they are counted as they pass
	always @(posedge clk) begin
		if (acc === 1'b1) n_acc <= n_acc + 8'h01;
		if (xgo === 1'b1) n_go <= n_go + 8'h01;
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// a run is about 120 cycles; the ceiling only catches a hang
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e, g, m);
		checked++;
		if ((g & m) !== (e & m)) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e & m, g & m);
		end
	endtask

	task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e, m);
		pcs_host_model_i.bus_read(a, v);
		chk(n, e, v, m);
	endtask

	task automatic pulse_pkt(input logic nx);
		@(posedge clk);
		pkt  <= 1'b1;
		need <= nx;
		@(posedge clk);
		pkt <= 1'b0;
	endtask

	task automatic pulse_fin(input logic [3:0] sk, input logic [3:0] f);
		@(posedge clk);
		fin   <= 1'b1;
		sense <= sk;
		{abrt, eom, ili, flt} <= f;
		@(posedge clk);
		fin <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		rchk("status", ADR_STAT_CMD, 8'h40, 8'hFF);
		rchk("error", ADR_ERR_FEAT, 8'h00, 8'hFF);
		rchk("reason", ADR_IRSN_CNT, 8'h00, 8'hFF);
		rchk("ident", ADR_IDENT, 8'h01, 8'hFF);
		pcs_host_model_i.bus_write(ADR_DEVSEL, 8'h5A);
		rchk("devsel", ADR_DEVSEL, 8'h5A, 8'hFF);
		pcs_host_model_i.bus_write(ADR_CTRL, 8'hFF);
		rchk("ctrl", ADR_CTRL, 8'h03, 8'hFF);
		rchk("unmapped", 3'h7, 8'h00, 8'hFF);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, 8'h55);
		rchk("bad cmd", ADR_STAT_CMD, 8'h40, 8'hFF);
	endtask

	// overlapped command with release interrupt on: release, service, data, clean end
	task automatic test_release;
		pcs_host_model_i.bus_write(ADR_ERR_FEAT, 8'h02);
		pcs_host_model_i.bus_write(ADR_CTRL, 8'h01);
		pcs_host_model_i.bus_write(ADR_IRSN_CNT, 8'h28);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, CMD_PACKET);
		rchk("await status", ADR_STAT_CMD, 8'h08, 8'h88);
		chk("active", 8'h01, {7'h00, act}, 8'h01);
		pulse_pkt(1'b1);
		rchk("rel reason", ADR_IRSN_CNT, 8'h2C, 8'hFF);
		pcs_host_model_i.bus_read(ADR_STAT_CMD, s);
		chk("rel status", 8'h00, s, 8'hA9);
		@(posedge clk);
		rdy <= 1'b1;
		rchk("serv status", ADR_STAT_CMD, s | 8'h10, 8'hFF);
		rchk("serv reason", ADR_IRSN_CNT, 8'h2C, 8'hFF);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, CMD_SERVICE);
		rdy <= 1'b0;
		rchk("data status", ADR_STAT_CMD, 8'h08, 8'h89);
		rchk("data reason", ADR_IRSN_CNT, 8'h2A, 8'hFF);
		@(posedge clk);
		done <= 1'b1;
		oq   <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		pulse_fin(4'h0, 4'h0);
		rchk("end status", ADR_STAT_CMD, 8'h50, 8'hF9);
		rchk("end reason", ADR_IRSN_CNT, 8'h2B, 8'hFF);
		chk("idle", 8'h00, {7'h00, act}, 8'h01);
		oq <= 1'b0;
	endtask

	// plain command: early finish ignored, busy after packet, error end with fault
	task automatic test_error;
		pcs_host_model_i.bus_write(ADR_ERR_FEAT, 8'h00);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, CMD_PACKET);
		pulse_fin(4'hA, 4'b1101);
		rchk("early fin", ADR_STAT_CMD, 8'h08, 8'h88);
		pulse_pkt(1'b0);
		rchk("busy", ADR_STAT_CMD, 8'h80, 8'h88);
		pulse_fin(4'hA, 4'b1101);
		rchk("err code", ADR_ERR_FEAT, 8'hA6, 8'hFF);
		rchk("err status", ADR_STAT_CMD, 8'h61, 8'hE9);
		rchk("err reason", ADR_IRSN_CNT, 8'h03, 8'h07);
	endtask

	// optional release allowed: data ready at once, then release before a held finish
	task automatic test_direct;
		pcs_host_model_i.bus_write(ADR_ERR_FEAT, 8'h02);
		pcs_host_model_i.bus_write(ADR_CTRL, 8'h02);
		pcs_host_model_i.bus_write(ADR_IRSN_CNT, 8'h08);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, CMD_PACKET);
		rdy <= 1'b1;
		pulse_pkt(1'b1);
		rchk("direct reason", ADR_IRSN_CNT, 8'h0A, 8'hFF);
		rchk("direct status", ADR_STAT_CMD, 8'h08, 8'h89);
		@(posedge clk);
		rdy  <= 1'b0;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		rchk("late release", ADR_IRSN_CNT, 8'h0C, 8'hFF);
		rchk("late rel status", ADR_STAT_CMD, 8'h00, 8'hBF);
		pulse_fin(4'h3, 4'b0100);
		rchk("fin serv", ADR_STAT_CMD, 8'h50, 8'hFF);
		rchk("fin serv reason", ADR_IRSN_CNT, 8'h0C, 8'hFF);
		pcs_host_model_i.bus_write(ADR_STAT_CMD, CMD_SERVICE);
		rchk("held err", ADR_ERR_FEAT, 8'h32, 8'hFF);
		rchk("held status", ADR_STAT_CMD, 8'h41, 8'hFF);
		rchk("held reason", ADR_IRSN_CNT, 8'h0B, 8'hFF);
		chk("accepts", 8'h03, n_acc, 8'hFF);
		chk("xfer go", 8'h02, n_go, 8'hFF);
	endtask

	task automatic results;
		if (num_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		{rst, oq, pkt, need, rdy, done, fin, abrt, eom, ili, flt} = 11'h400;
		sense = 4'h0;
		num_errors = 0;
		checked = 0;
		cyc = 0;
		n_acc = 8'h00;
		n_go = 8'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		test_regs();
		test_release();
		test_error();
		test_direct();
		results();
	end
endmodule
